// ---- design/dbg_map.svh ----
// offsets, field positions, reset values and mode codes of the debug trigger block
`ifndef DBG_MAP_SVH
`define DBG_MAP_SVH
`define OFS_CTRL         12'h000
`define OFS_TRIG         12'h004
`define OFS_STAT         12'h008
`define OFS_FIFO_HI      12'h00C
`define OFS_FIFO_LO      12'h010
`define CTRL_EN_BIT      7
`define CTRL_ARM_BIT     6
`define CTRL_TAG_BIT     5
`define CTRL_BRK_BIT     4
`define TRIG_QUAL_BIT    7
`define TRIG_BEGIN_BIT   6
`define TRIG_WR_MASK     8'hCF
`define CTRL_RESET       8'h00
`define TRIG_RESET       8'h00
`define FIFO_DEPTH       8
`define FIFO_WIDTH       16
`define MODE_A_ONLY      4'h0
`define MODE_A_OR_B      4'h1
`define MODE_A_THEN_B    4'h2
`define MODE_EV_B        4'h3
`define MODE_A_THEN_EV_B 4'h4
`define MODE_A_AND_B     4'h5
`define MODE_A_NOT_B     4'h6
`define MODE_INSIDE      4'h7
`define MODE_OUTSIDE     4'h8
`endif

// ---- design/dbg_pkg.sv ----
// types of the debug trigger block
package dbg_pkg;
  typedef enum logic [1:0] {RUN_IDLE, RUN_WAIT, RUN_CAPTURE, RUN_FILL} run_state_e;
  typedef struct packed {
    run_state_e state;
    logic [7:0] ctrl;
    logic [7:0] trig;
    logic       flag_a;
    logic       flag_b;
    logic       brk;
  } ctl_s;
endpackage : dbg_pkg

// ---- design/fifo_if.sv ----
// link between the run control and the trace memory
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 16, parameter int D = 8);
  logic                 store;
  logic [W-1:0]         wdata;
  logic                 clear;
  logic                 circular;
  logic                 advance;
  logic [W-1:0]         rdata;
  logic [$clog2(D):0]   count;
  logic                 full;
  modport ctrl (output store, wdata, clear, circular, advance, input rdata, count, full);
  modport mem (input store, wdata, clear, circular, advance, output rdata, count, full);
endinterface : fifo_if

// ---- design/trace_fifo.sv ----
// eight word trace memory with fill count and registered read word
`timescale 1ns/1ps
`include "dbg_map.svh"
module trace_fifo #(
  parameter int W = `FIFO_WIDTH,
  parameter int D = `FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  fifo_if.mem      f
);
  localparam int AW = $clog2(D);
  localparam int CW = AW + 1;
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
    logic [W-1:0]        rd;
  } fifo_s;
  fifo_s st_reg;
  fifo_s st_next;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : inc

  always_comb begin
    st_next    = st_reg;
    st_next.rd = st_reg.mem[st_reg.rp];
    if (f.clear) begin
      st_next.wp  = '0;
      st_next.rp  = '0;
      st_next.cnt = '0;
    end else if (f.store && (f.full == 1'b0 || f.circular)) begin
      st_next.mem[st_reg.wp] = f.wdata;
      st_next.wp             = inc(st_reg.wp);
      if (f.full) begin
        st_next.rp = inc(st_reg.rp);
      end else begin
        st_next.cnt = CW'(st_reg.cnt + 1'b1);
      end
    end else if (f.advance) begin
      st_next.rp = inc(st_reg.rp);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign f.rdata = st_reg.rd;
  assign f.count = st_reg.cnt;
  assign f.full  = (st_reg.cnt == CW'(D));
endmodule : trace_fifo

// ---- design/trigger_qualify.sv ----
// trigger mode decode and opcode qualification of comparator matches
`timescale 1ns/1ps
`include "dbg_map.svh"
module trigger_qualify (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic       start,
  input  wire logic [3:0] mode,
  input  wire logic       tag_sel,
  input  wire logic       bus_valid,
  input  wire logic       opcode_fetch,
  input  wire logic       opcode_exec,
  input  wire logic       a_hit,
  input  wire logic       b_hit,
  input  wire logic       b_data_hit,
  input  wire logic       addr_ge_a,
  input  wire logic       addr_le_b,
  output logic            hit_a,
  output logic            hit_b,
  output logic            trigger,
  output logic            event_only,
  output logic            event_store
);
  typedef struct packed {
    logic tag_a;
    logic tag_b;
    logic a_seen;
  } trig_s;
  trig_s st_reg;
  trig_s st_next;
  logic  raw_a;
  logic  raw_b;

  always_comb begin
    st_next = st_reg;
    raw_a   = a_hit;
    raw_b   = b_hit;
    case (mode)
      `MODE_A_ONLY: raw_b = 1'b0;
      `MODE_A_OR_B, `MODE_A_THEN_B: ;
      `MODE_EV_B, `MODE_A_THEN_EV_B: ;
      `MODE_A_AND_B: begin
        raw_a = a_hit & b_data_hit;
        raw_b = 1'b0;
      end
      `MODE_A_NOT_B: begin
        raw_a = a_hit & !b_data_hit;
        raw_b = 1'b0;
      end
      `MODE_INSIDE: begin
        raw_a = addr_ge_a & addr_le_b;
        raw_b = 1'b0;
      end
      `MODE_OUTSIDE: begin
        raw_a = !(addr_ge_a & addr_le_b);
        raw_b = 1'b0;
      end
      default: begin
        raw_a = 1'b0;
        raw_b = 1'b0;
      end
    endcase
    if (bus_valid && opcode_fetch) begin
      st_next.tag_a = raw_a;
      st_next.tag_b = raw_b;
    end else if (opcode_exec) begin
      st_next.tag_a = 1'b0;
      st_next.tag_b = 1'b0;
    end
    if (tag_sel) begin
      hit_a = run & opcode_exec & st_reg.tag_a;
      hit_b = run & opcode_exec & st_reg.tag_b;
    end else begin
      hit_a = run & bus_valid & raw_a;
      hit_b = run & bus_valid & raw_b;
    end
    if (start) begin
      st_next.a_seen = 1'b0;
    end else if (hit_a) begin
      st_next.a_seen = 1'b1;
    end
    event_only  = (mode == `MODE_EV_B) || (mode == `MODE_A_THEN_EV_B);
    event_store = event_only & hit_b & ((mode == `MODE_EV_B) | st_reg.a_seen);
    case (mode)
      `MODE_A_OR_B: trigger = hit_a | hit_b;
      `MODE_A_THEN_B: trigger = hit_b & st_reg.a_seen;
      `MODE_EV_B, `MODE_A_THEN_EV_B: trigger = 1'b0;
      default: trigger = hit_a;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : trigger_qualify

// ---- design/debug_trigger_status_logic.sv ----
// debug trigger selection, run control and run status with apb registers
`timescale 1ns/1ps
`include "dbg_map.svh"
module debug_trigger_status_logic
  import dbg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mcu_secure,
  input  wire logic        bus_valid,
  input  wire logic        opcode_fetch,
  input  wire logic        opcode_exec,
  input  wire logic        comp_a_hit,
  input  wire logic        comp_b_hit,
  input  wire logic        comp_b_data_hit,
  input  wire logic        addr_ge_a,
  input  wire logic        addr_le_b,
  input  wire logic        trace_valid,
  input  wire logic [15:0] trace_word,
  input  wire logic [7:0]  event_byte,
  output logic             run_active,
  output logic [3:0]       comp_rw_ctrl,
  output logic             break_request,
  output logic             break_tag
);

  // ****************************************
  // state and internal signals
  // ****************************************

  ctl_s       st_reg;
  ctl_s       st_next;
  logic       wr_en;
  logic       rd_en;
  logic       run_start;
  logic       arm_keep;
  logic [7:0] ctrl_wd;
  logic [7:0] status_byte;
  logic       hit_a;
  logic       hit_b;
  logic       trig_evt;
  logic       ev_only;
  logic       ev_store;

  fifo_if #(.W(`FIFO_WIDTH), .D(`FIFO_DEPTH)) fif ();

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] o);
    addr_is = (a[11:2] == o[11:2]);
  endfunction : addr_is

  // ****************************************
  // submodules
  // ****************************************

  trigger_qualify u_trig (
    .pclk         (pclk),
    .presetn      (presetn),
    .run          (st_reg.state != RUN_IDLE),
    .start        (run_start),
    .mode         (st_reg.trig[3:0]),
    .tag_sel      (st_reg.trig[`TRIG_QUAL_BIT]),
    .bus_valid    (bus_valid),
    .opcode_fetch (opcode_fetch),
    .opcode_exec  (opcode_exec),
    .a_hit        (comp_a_hit),
    .b_hit        (comp_b_hit),
    .b_data_hit   (comp_b_data_hit),
    .addr_ge_a    (addr_ge_a),
    .addr_le_b    (addr_le_b),
    .hit_a        (hit_a),
    .hit_b        (hit_b),
    .trigger      (trig_evt),
    .event_only   (ev_only),
    .event_store  (ev_store)
  );

  trace_fifo #(
    .W (`FIFO_WIDTH),
    .D (`FIFO_DEPTH)
  ) u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (fif)
  );

  // ****************************************
  // apb strobes
  // ****************************************

  assign wr_en  = psel & penable & pwrite;
  assign rd_en  = psel & penable & !pwrite;
  assign pready = 1'b1;

  // ****************************************
  // run control
  // ****************************************

  always_comb begin
    st_next      = st_reg;
    st_next.brk  = 1'b0;
    run_start    = 1'b0;
    arm_keep     = 1'b0;
    ctrl_wd      = pwdata[7:0];
    fif.store    = 1'b0;
    fif.wdata    = trace_word;
    fif.clear    = 1'b0;
    fif.circular = (st_reg.state == RUN_FILL);
    fif.advance  = 1'b0;

    if (hit_a) begin
      st_next.flag_a = 1'b1;
    end
    if (hit_b) begin
      st_next.flag_b = 1'b1;
    end

    case (st_reg.state)
      RUN_WAIT: begin
        if (trig_evt) begin
          st_next.state = RUN_CAPTURE;
        end
      end
      RUN_CAPTURE: begin
        if (ev_only) begin
          fif.store = ev_store;
          fif.wdata = {8'h00, event_byte};
        end else begin
          fif.store = trace_valid;
        end
        if (fif.full) begin
          st_next.state                = RUN_IDLE;
          st_next.ctrl[`CTRL_ARM_BIT]  = 1'b0;
          st_next.brk                  = st_reg.ctrl[`CTRL_BRK_BIT];
        end
      end
      RUN_FILL: begin
        fif.store = trace_valid;
        if (trig_evt) begin
          st_next.state                = RUN_IDLE;
          st_next.ctrl[`CTRL_ARM_BIT]  = 1'b0;
          st_next.brk                  = st_reg.ctrl[`CTRL_BRK_BIT];
        end
      end
      default: ;
    endcase

    // ****************************************
    // register writes
    // ****************************************

    if (wr_en && addr_is(paddr, `OFS_CTRL)) begin
      arm_keep = st_next.ctrl[`CTRL_ARM_BIT];
      if (mcu_secure && !st_reg.ctrl[`CTRL_EN_BIT]) begin
        ctrl_wd[`CTRL_EN_BIT] = 1'b0;
      end
      st_next.ctrl = ctrl_wd;
      if (!ctrl_wd[`CTRL_EN_BIT] || !ctrl_wd[`CTRL_ARM_BIT]) begin
        st_next.ctrl[`CTRL_ARM_BIT] = 1'b0;
        st_next.state               = RUN_IDLE;
      end else if (st_reg.state == RUN_IDLE) begin
        run_start      = 1'b1;
        st_next.flag_a = 1'b0;
        st_next.flag_b = 1'b0;
        fif.clear      = 1'b1;
        if (ev_only) begin
          st_next.state = RUN_CAPTURE;
        end else if (st_reg.trig[`TRIG_BEGIN_BIT]) begin
          st_next.state = RUN_WAIT;
        end else begin
          st_next.state = RUN_FILL;
        end
      end else begin
        st_next.ctrl[`CTRL_ARM_BIT] = arm_keep;
      end
    end else if (wr_en && addr_is(paddr, `OFS_TRIG)) begin
      if (!st_reg.ctrl[`CTRL_ARM_BIT]) begin
        st_next.trig = pwdata[7:0] & `TRIG_WR_MASK;
      end
    end

    if (rd_en && addr_is(paddr, `OFS_FIFO_LO) && st_reg.state == RUN_IDLE) begin
      fif.advance = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg        <= '0;
      st_reg.state  <= RUN_IDLE;
      st_reg.ctrl   <= `CTRL_RESET;
      st_reg.trig   <= `TRIG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // read side
  // ****************************************

  always_comb begin
    status_byte    = 8'h00;
    status_byte[7] = st_reg.flag_a;
    status_byte[6] = st_reg.flag_b;
    status_byte[5] = st_reg.ctrl[`CTRL_ARM_BIT] & st_reg.ctrl[`CTRL_EN_BIT];
    status_byte[3:0] = fif.count;
  end

  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (addr_is(paddr, `OFS_CTRL)) begin
      prdata[7:0] = st_reg.ctrl;
    end else if (addr_is(paddr, `OFS_TRIG)) begin
      prdata[7:0] = st_reg.trig & `TRIG_WR_MASK;
    end else if (addr_is(paddr, `OFS_STAT)) begin
      prdata[7:0] = status_byte;
    end else if (addr_is(paddr, `OFS_FIFO_HI)) begin
      prdata[7:0] = fif.rdata[15:8];
    end else if (addr_is(paddr, `OFS_FIFO_LO)) begin
      prdata[7:0] = fif.rdata[7:0];
    end else begin
      pslverr = psel & penable;
    end
  end

  // ****************************************
  // outputs
  // ****************************************

  assign run_active    = (st_reg.state != RUN_IDLE);
  assign comp_rw_ctrl  = st_reg.ctrl[3:0];
  assign break_request = st_reg.brk;
  assign break_tag     = st_reg.ctrl[`CTRL_TAG_BIT];

endmodule : debug_trigger_status_logic

// ---- tb/dbg_status_properties.sv ----
// port checks of the debug trigger and run status block
`timescale 1ns/1ps
`include "dbg_map.svh"
module dbg_status_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        mcu_secure,
  input wire logic        run_active,
  input wire logic        break_request
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****************
  // sequences
  // ****************
  sequence s_rd(a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  sequence s_ctrl_wr;
    psel && penable && pwrite && paddr == `OFS_CTRL;
  endsequence
  property p_trig_rsv;
    s_rd(`OFS_TRIG) |-> prdata[5:4] == 2'b00;
  endproperty
  property p_stat_arm;
    s_rd(`OFS_STAT) |-> prdata[5] == run_active;
  endproperty
  property p_stat_cnt;
    s_rd(`OFS_STAT) |-> prdata[3:0] <= 4'h8 && !prdata[4];
  endproperty
  property p_stop;
    s_ctrl_wr ##0 (pwdata[7:6] != 2'b11) |=> !run_active;
  endproperty
  property p_start;
    s_ctrl_wr ##0 (pwdata[7:6] == 2'b11 && !mcu_secure) |=> run_active;
  endproperty
  property p_rise;
    $rose(run_active) |-> $past(psel && penable && pwrite && paddr == `OFS_CTRL && pwdata[6]);
  endproperty
  property p_brk_end;
    break_request |-> !run_active && ($past(run_active) || $past(run_active, 2));
  endproperty
  property p_brk_pulse;
    break_request |=> !break_request;
  endproperty
  property p_unmapped;
    psel && penable && paddr[11:2] > 10'h004 |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_trig_rsv: assert property (p_trig_rsv) else $error("trigger reserved bits set");
  a_stat_arm: assert property (p_stat_arm) else $error("arm flag differs from run");
  a_stat_cnt: assert property (p_stat_cnt) else $error("valid count out of range");
  a_stop: assert property (p_stop) else $error("run kept after stop write");
  a_start: assert property (p_start) else $error("run not started");
  a_rise: assert property (p_rise) else $error("run began without arm write");
  a_brk_end: assert property (p_brk_end) else $error("break not at run end");
  a_brk_pulse: assert property (p_brk_pulse) else $error("break longer than a cycle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
endmodule : dbg_status_checker
bind debug_trigger_status_logic dbg_status_checker u_chk (
  .pclk          (pclk),
  .presetn       (presetn),
  .paddr         (paddr),
  .psel          (psel),
  .penable       (penable),
  .pwrite        (pwrite),
  .pwdata        (pwdata),
  .prdata        (prdata),
  .pslverr       (pslverr),
  .mcu_secure    (mcu_secure),
  .run_active    (run_active),
  .break_request (break_request)
);

// ---- tb/trace_host.sv ----
// debug host model: apb master and trace readout
`timescale 1ns/1ps
`include "dbg_map.svh"
module trace_host (
  input  wire logic        pclk,
  output logic      [11:0] paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  initial begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
  end
  // ****************
  // bus cycle
  // ****************
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] rd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) debug_trigger_status_logic_tb.hang();
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic read_trace(input int cnt, output logic [15:0] q[$]);
    logic [31:0] hi;
    logic [31:0] lo;
    q = {};
    while (cnt > 0) begin
      xfer(1'b0, `OFS_FIFO_HI, 8'h00, hi);
      xfer(1'b0, `OFS_FIFO_LO, 8'h00, lo);
      q.push_back({hi[7:0], lo[7:0]});
      cnt--;
    end
  endtask : read_trace
endmodule : trace_host

// ---- tb/debug_trigger_status_logic_tb.sv ----
// self-checking bench of the debug trigger and run status block
`timescale 1ns/1ps
`include "dbg_map.svh"
module debug_trigger_status_logic_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, noise, r;
  logic        bus_valid, comp_a_hit, comp_b_hit, trace_valid;
  logic        run_active, break_request;
  logic        opf, opx, ev_mode;
  logic [7:0]  tv_byte;
  logic [15:0] q[$];
  logic [15:0] words[$];
  int          bad_count, checks, brk_seen;
  int          seed = 32'h0000_c8b0;
  trace_host host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready));
  debug_trigger_status_logic dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mcu_secure(1'b0), .bus_valid(bus_valid),
    .opcode_fetch(opf), .opcode_exec(opx), .comp_a_hit(comp_a_hit),
    .comp_b_hit(comp_b_hit), .comp_b_data_hit(noise[0]), .addr_ge_a(noise[1]),
    .addr_le_b(noise[2]), .trace_valid(trace_valid), .trace_word(noise[31:16]),
    .event_byte(noise[15:8]), .run_active(run_active), .comp_rw_ctrl(),
    .break_request(break_request), .break_tag());
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    noise <= $random(seed);
    if (break_request === 1'b1) brk_seen++;
  end
  function automatic logic [31:0] stat_exp(logic af, logic bf, logic arm, logic [3:0] cnt);
    return {24'h00_0000, af, bf, arm, 1'b0, cnt};
  endfunction : stat_exp
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [11:0] a, logic [7:0] d);
    host.xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rdc(string name, logic [11:0] a, logic [31:0] exp);
    host.xfer(1'b0, a, 8'h00, r);
    chk(name, r, exp);
  endtask : rdc
  task automatic cpu(logic a, logic b, logic tv, logic keep);
    bus_valid <= a | b;
    comp_a_hit <= a;
    comp_b_hit <= b;
    trace_valid <= tv;
    @(posedge pclk);
    if (ev_mode && b) words.push_back({8'h00, noise[15:8]});
    else if (tv && keep) words.push_back(noise[31:16]);
  endtask : cpu
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  task automatic hang;
    bad_count++;
    close_out();
  endtask : hang
  // ****************
  // main sequence
  // ****************
  initial begin
    presetn = 1'b0;
    noise = 32'h0000_0000;
    opf = 1'b0;
    opx = 1'b0;
    ev_mode = 1'b0;
    cpu(0, 0, 0, 0);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("ctrl reset", `OFS_CTRL, 32'h0000_0000);
    rdc("stat reset", `OFS_STAT, stat_exp(0, 0, 0, 0));
    wr(`OFS_STAT, 8'hff);
    rdc("stat write", `OFS_STAT, stat_exp(0, 0, 0, 0));
    rdc("unmapped", 12'h040, 32'h0000_0000);
    for (int m = 0; m < 16; m++) begin
      tv_byte = noise[23:16];
      wr(`OFS_TRIG, {tv_byte[7:4], m[3:0]});
      rdc("trig", `OFS_TRIG, {24'h00_0000, tv_byte[7:4] & 4'hc, m[3:0]});
    end
    $display("test registers done");
    wr(`OFS_TRIG, 8'h40);
    wr(`OFS_CTRL, 8'hd0);
    wr(`OFS_TRIG, 8'h8f);
    rdc("trig armed", `OFS_TRIG, 32'h0000_0040);
    rdc("stat armed", `OFS_STAT, stat_exp(0, 0, 1, 0));
    cpu(0, 0, 1, 0);
    cpu(1, 0, 0, 0);
    cpu(0, 0, 0, 0);
    repeat (8) cpu(0, 0, 1, 1);
    repeat (3) cpu(0, 0, 0, 0);
    rdc("stat begin", `OFS_STAT, stat_exp(1, 0, 0, 8));
    chk("break count", brk_seen, 1);
    host.read_trace(8, q);
    for (int i = 0; i < 8; i++) chk("begin word", q[i], words[i]);
    rdc("stat kept", `OFS_STAT, stat_exp(1, 0, 0, 8));
    $display("test begin trace done");
    words = {};
    wr(`OFS_TRIG, 8'h01);
    wr(`OFS_CTRL, 8'hc0);
    repeat (11) cpu(0, 0, 1, 1);
    cpu(0, 1, 1, 1);
    repeat (3) cpu(0, 0, 0, 0);
    rdc("stat end", `OFS_STAT, stat_exp(0, 1, 0, 8));
    host.read_trace(8, q);
    for (int i = 0; i < 8; i++) chk("end word", q[i], words[i + 4]);
    chk("no break", brk_seen, 1);
    $display("test end trace done");
    words = {};
    ev_mode = 1'b1;
    wr(`OFS_TRIG, 8'h03);
    wr(`OFS_CTRL, 8'hc0);
    rdc("stat event", `OFS_STAT, stat_exp(0, 0, 1, 0));
    repeat (8) cpu(0, 1, 0, 0);
    repeat (3) cpu(0, 0, 0, 0);
    rdc("stat event end", `OFS_STAT, stat_exp(0, 1, 0, 8));
    host.read_trace(8, q);
    for (int i = 0; i < 8; i++) chk("event word", q[i], words[i]);
    ev_mode = 1'b0;
    wr(`OFS_TRIG, 8'hc0);
    wr(`OFS_CTRL, 8'hc0);
    opf <= 1'b1;
    cpu(1, 0, 0, 0);
    opf <= 1'b0;
    rdc("tag fetch", `OFS_STAT, stat_exp(0, 0, 1, 0));
    opx <= 1'b1;
    cpu(0, 0, 0, 0);
    opx <= 1'b0;
    cpu(0, 0, 0, 0);
    rdc("tag exec", `OFS_STAT, stat_exp(1, 0, 1, 0));
    wr(`OFS_CTRL, 8'h80);
    $display("test event and tag done");
    wr(`OFS_TRIG, 8'h49);
    wr(`OFS_CTRL, 8'hc0);
    cpu(1, 0, 1, 0);
    cpu(0, 1, 1, 0);
    cpu(1, 1, 1, 0);
    cpu(0, 0, 0, 0);
    host.xfer(1'b0, `OFS_STAT, 8'h00, r);
    chk("no trigger", r[5:0], 6'h20);
    wr(`OFS_CTRL, 8'h80);
    host.xfer(1'b0, `OFS_STAT, 8'h00, r);
    chk("arm stop", r[5:0], 6'h00);
    wr(`OFS_CTRL, 8'hc0);
    wr(`OFS_CTRL, 8'h40);
    chk("enable stop", {31'h0000_0000, run_active}, 32'h0000_0000);
    $display("test stop done");
    close_out();
  end
endmodule : debug_trigger_status_logic_tb
